// ### rtl/pesw_defines.svh
// Purpose: offsets, field positions, reset values of the event status window
// Assumes: 16-bit management registers, 8-bit expanded locations
// Notes: included by the window module and both verification files
`ifndef PESW_DEFINES_SVH
`define PESW_DEFINES_SVH
`define PESW_ADDR_MODE 5'h16
`define PESW_ADDR_DATA 5'h1D
`define PESW_ADDR_PTR 5'h1E
`define PESW_EXP_STAT_LO 16'h810D
`define PESW_EXP_STAT_HI 16'h810E
`define PESW_EXP_CLR_LO 16'h8115
`define PESW_EXP_CLR_HI 16'h8116
`define PESW_MODE_EN_BIT 2
`define PESW_MODE_RST 4'h3
`define PESW_DATA_RST 16'h0000
`define PESW_PTR_RST 16'h0000
`define PESW_STAT_LO_RST 8'h00
`define PESW_STAT_HI_RST 8'h01
`define PESW_BS_NEG_DONE 5
`define PESW_BS_REM_FAULT 4
`define PESW_BS_JABBER 1
`define PESW_SS_SPEED_HI 4
`define PESW_SS_SPEED_LO 3
`define PESW_SS_LINK 2
`define PESW_SS_DUPLEX 1
`define PESW_GS_CFG_FAULT 15
`define PESW_GS_MASTER 14
`define PESW_GS_LOC_RCVR 13
`define PESW_GS_REM_RCVR 12
`endif

// ### rtl/pesw_pkg.sv
// Purpose: types of the event status window
// Assumes: nothing
// Notes: access width codes of the mode field
package pesw_pkg;
    typedef enum logic [1:0] {
        PESW_W_RES0 = 2'b00,
        PESW_W_8 = 2'b01,
        PESW_W_16 = 2'b10,
        PESW_W_RES3 = 2'b11
    } pesw_width_t;
endpackage

// ### rtl/pesw_sticky.sv
// Purpose: sticky status bits with per-bit set and clear
// Assumes: set and clear are single-cycle or level inputs on sys_clk
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module pesw_sticky #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // events
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    // status
    output logic [W-1:0] q
);
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            q <= RST;
        end else begin
            q <= (q & ~clr) | set;
        end
    end
endmodule // pesw_sticky
`default_nettype wire

// ### rtl/pesw_change.sv
// Purpose: per-bit change detection of same-clock status flags
// Assumes: inputs come from logic on sys_clk
// Notes: no event on the first cycle after reset
`timescale 1ns/1ps
`default_nettype none
module pesw_change #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // watched flags
    input wire logic [W-1:0] cur,
    // per-bit change
    output logic [W-1:0] changed,
    output logic armed
);
    logic [W-1:0] prev;
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prev <= '0;
        end else begin
            prev <= cur;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
        end
    end
    assign changed = armed ? (cur ^ prev) : '0;
endmodule // pesw_change
`default_nettype wire

// ### rtl/pesw_event_window.sv
// Purpose: event status bits behind an indirect expanded-memory window
// Assumes: management port already decoded from the serial interface
// Notes: status inputs and counters run on sys_clk
`include "pesw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pesw_event_window
    import pesw_pkg::*;
#(
    parameter int CW = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // management register port
    input wire logic [4:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    output logic mgmt_rvalid,
    // device status registers
    input wire logic [15:0] basic_status,
    input wire logic [15:0] support_status,
    input wire logic [15:0] gigabit_status,
    // counters and limits
    input wire logic [CW-1:0] negotiation_counter,
    input wire logic [CW-1:0] negotiation_count_limit,
    input wire logic [CW-1:0] link_count_10,
    input wire logic [CW-1:0] link_count_100,
    input wire logic [CW-1:0] link_count_1000,
    input wire logic [CW+1:0] link_count_limit,
    input wire logic [7:0] idle_error_limit,
    // firmware
    input wire logic firmware_in_rom,
    input wire logic firmware_reset_seen,
    // status view
    output logic [7:0] event_status_low,
    output logic [7:0] event_status_high
);
    import pesw_pkg::*;

    generate
        if (CW < 1 || CW > 16) begin : g_bad_cw
            $error("counter width out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // management registers
    logic [3:0] window_mode;
    logic [15:0] window_data;
    logic [15:0] window_pointer;
    pesw_width_t acc_w;
    logic exp_ok;
    logic wr_mode;
    logic wr_data;
    logic wr_ptr;

    assign acc_w = pesw_width_t'(window_mode[1:0]);
    // reserved widths and a cleared enable both shut the window
    assign exp_ok = window_mode[`PESW_MODE_EN_BIT]
        && (acc_w == PESW_W_8 || acc_w == PESW_W_16);
    assign wr_mode = mgmt_wr && mgmt_addr == `PESW_ADDR_MODE;
    assign wr_data = mgmt_wr && mgmt_addr == `PESW_ADDR_DATA;
    assign wr_ptr = mgmt_wr && mgmt_addr == `PESW_ADDR_PTR;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            window_mode <= `PESW_MODE_RST;
        end else if (wr_mode) begin
            window_mode <= mgmt_wdata[3:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            window_data <= `PESW_DATA_RST;
        end else if (wr_data) begin
            window_data <= mgmt_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            window_pointer <= `PESW_PTR_RST;
        end else if (wr_ptr) begin
            window_pointer <= mgmt_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // expanded memory byte map
    logic [15:0] ptr_next;
    assign ptr_next = window_pointer + 16'h0001;

    function automatic logic [7:0] exp_byte(input logic [15:0] a,
                                            input logic [7:0] lo,
                                            input logic [7:0] hi);
        logic [7:0] r;
        r = 8'h00;
        if (a == `PESW_EXP_STAT_LO) begin
            r = lo;
        end else if (a == `PESW_EXP_STAT_HI) begin
            r = hi;
        end
        return r;
    endfunction

    // byte that a window write delivers to expanded address t
    function automatic logic [7:0] clr_byte(input logic [15:0] t,
                                            input logic [15:0] p,
                                            input logic [15:0] pn,
                                            input pesw_width_t w,
                                            input logic [15:0] d);
        logic [7:0] r;
        r = 8'h00;
        if (p == t) begin
            r = d[7:0];
        end else if (w == PESW_W_16 && pn == t) begin
            r = d[15:8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // clear strobes
    logic [7:0] clr_low;
    logic [7:0] clr_high;
    logic win_wr;
    assign win_wr = wr_data && exp_ok;
    assign clr_low = win_wr ? clr_byte(`PESW_EXP_CLR_LO, window_pointer, ptr_next, acc_w,
        mgmt_wdata) : 8'h00;
    assign clr_high = win_wr ? clr_byte(`PESW_EXP_CLR_HI, window_pointer, ptr_next, acc_w,
        mgmt_wdata) : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // event sources
    logic [15:0] watch;
    logic [15:0] chg;
    logic armed;
    logic link_up;
    logic [CW+1:0] link_sum;
    logic [7:0] set_low;
    logic [5:0] set_high;
    logic [7:0] stat_low;
    logic [5:0] stat_high_q;
    logic fw_rom;
    logic fw_ram;

    assign link_up = support_status[`PESW_SS_LINK];
    assign watch = {8'h00,
        basic_status[`PESW_BS_NEG_DONE], basic_status[`PESW_BS_REM_FAULT],
        support_status[`PESW_SS_SPEED_HI], support_status[`PESW_SS_SPEED_LO],
        support_status[`PESW_SS_LINK], support_status[`PESW_SS_DUPLEX],
        basic_status[`PESW_BS_JABBER], 1'b0} |
        {gigabit_status[`PESW_GS_CFG_FAULT], gigabit_status[`PESW_GS_MASTER],
        gigabit_status[`PESW_GS_LOC_RCVR], gigabit_status[`PESW_GS_REM_RCVR], 12'h000};
    assign link_sum = {2'b00, link_count_10} + {2'b00, link_count_100}
        + {2'b00, link_count_1000};

    pesw_change #(.W(16)) u_change (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .cur(watch),
        .changed(chg),
        .armed(armed)
    );

    assign set_low[7] = negotiation_counter > negotiation_count_limit;
    assign set_low[6] = chg[7];
    assign set_low[5] = chg[6];
    assign set_low[4] = (chg[5] | chg[4]) & link_up;
    assign set_low[3] = link_sum > link_count_limit;
    assign set_low[2] = chg[3];
    assign set_low[1] = chg[2] & link_up;
    assign set_low[0] = chg[1];
    assign set_high[5] = chg[15];
    assign set_high[4] = chg[14] & link_up;
    assign set_high[3] = chg[13];
    assign set_high[2] = chg[12];
    assign set_high[1] = gigabit_status[7:0] > idle_error_limit;
    assign set_high[0] = firmware_reset_seen;

    pesw_sticky #(.W(8), .RST(`PESW_STAT_LO_RST)) u_low (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .set(set_low),
        .clr(clr_low),
        .q(stat_low)
    );

    localparam logic [7:0] HI_RST = `PESW_STAT_HI_RST;
    // bits 7:3 and 0 of the high byte; bits 2:1 are live firmware location
    pesw_sticky #(.W(6), .RST({HI_RST[7:3], HI_RST[0]})) u_high (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .set(set_high),
        .clr({clr_high[7:3], clr_high[0]}),
        .q(stat_high_q)
    );

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fw_rom <= 1'b0;
        end else begin
            fw_rom <= firmware_in_rom;
        end
    end

    // own flop so the status byte comes straight from registers
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fw_ram <= 1'b1;
        end else begin
            fw_ram <= ~firmware_in_rom;
        end
    end

    assign event_status_low = stat_low;
    assign event_status_high = {stat_high_q[5:1], fw_rom, fw_ram, stat_high_q[0]};

    ////////////////////////////////////////////////////////////////////////////
    // read path
    logic [15:0] next_rdata;
    logic [7:0] rd_lo;
    logic [7:0] rd_hi;

    assign rd_lo = exp_byte(window_pointer, event_status_low, event_status_high);
    assign rd_hi = exp_byte(ptr_next, event_status_low, event_status_high);

    always_comb begin
        next_rdata = 16'h0000;
        unique case (mgmt_addr)
            `PESW_ADDR_MODE: next_rdata = {12'h000, window_mode};
            `PESW_ADDR_PTR: next_rdata = window_pointer;
            `PESW_ADDR_DATA: begin
                if (!exp_ok) begin
                    next_rdata = window_data;
                end else if (acc_w == PESW_W_8) begin
                    next_rdata = {8'h00, rd_lo};
                end else begin
                    next_rdata = {rd_hi, rd_lo};
                end
            end
            default: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_rd) begin
            mgmt_rdata <= next_rdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mgmt_rvalid <= 1'b0;
        end else begin
            mgmt_rvalid <= mgmt_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_ack_low6;
        win_wr && acc_w == PESW_W_8 && window_pointer == `PESW_EXP_CLR_LO
            && mgmt_wdata[6] && !set_low[6];
    endsequence

    rd_answer_a: assert property (mgmt_rd |=> mgmt_rvalid)
        else $error("read answer missing");
    ptr_store_a: assert property (wr_ptr |=> window_pointer == $past(mgmt_wdata))
        else $error("pointer not stored");
    mode_store_a: assert property (wr_mode |=> window_mode == $past(mgmt_wdata[3:0]))
        else $error("mode not stored");
    closed_read_a: assert property (mgmt_rd && mgmt_addr == `PESW_ADDR_DATA && !exp_ok
        |=> mgmt_rdata == $past(window_data))
        else $error("closed window read wrong");
    byte_read_a: assert property (mgmt_rd && mgmt_addr == `PESW_ADDR_DATA && exp_ok
        && acc_w == PESW_W_8 |=> mgmt_rdata[15:8] == 8'h00)
        else $error("8-bit read high byte not zero");
    ack_clear_a: assert property (s_ack_low6 |=> !event_status_low[6])
        else $error("acknowledge did not clear");
    neg_change_a: assert property (armed && $changed(basic_status[`PESW_BS_NEG_DONE])
        |=> event_status_low[6])
        else $error("negotiation change missed");
    jabber_change_a: assert property (armed && $changed(basic_status[`PESW_BS_JABBER])
        |=> event_status_low[0])
        else $error("jabber change missed");
    link_sum_a: assert property (link_sum > link_count_limit |=> event_status_low[3])
        else $error("link threshold missed");
    idle_err_a: assert property (gigabit_status[7:0] > idle_error_limit
        |=> event_status_high[3])
        else $error("idle error threshold missed");
    fw_bits_a: assert property (event_status_high[2] != event_status_high[1])
        else $error("firmware bits not complementary");
    fw_reset_a: assert property (firmware_reset_seen |=> event_status_high[0])
        else $error("firmware reset not latched");
    hold_set_a: assert property (event_status_low[2] && clr_low[2] == 1'b0
        |=> event_status_low[2])
        else $error("status dropped without acknowledge");
endmodule // pesw_event_window
`default_nettype wire

// ### verification/pesw_mgmt_model.sv
// Purpose: management controller model on the register port
// Assumes: one-cycle strobes, driven 2 ns after the rising edge
// Notes: idle port shows the inverse of the last address and data, strobes low
`include "pesw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module pesw_mgmt_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [4:0] mgmt_addr,
    output logic mgmt_wr,
    output logic mgmt_rd,
    output logic [15:0] mgmt_wdata
);
    initial begin
        mgmt_addr = 5'h00;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one request, released after the edge that takes it
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        #2;
        mgmt_addr = a;
        mgmt_wdata = d;
        mgmt_wr = w;
        mgmt_rd = ~w;
        @(posedge sys_clk);
        #2;
        mgmt_wr = 1'b0;
        mgmt_rd = 1'b0;
        mgmt_addr = ~a;
        mgmt_wdata = ~d;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a);
        xfer(1'b0, a, 16'h0000);
    endtask
    // open the window at a given width
    task automatic open_win(input logic [1:0] w);
        wr(`PESW_ADDR_MODE, {13'h0000, 1'b1, w});
    endtask
    // acknowledge through a clear location
    task automatic ack(input logic [15:0] p, input logic [15:0] m);
        wr(`PESW_ADDR_PTR, p);
        wr(`PESW_ADDR_DATA, m);
    endtask
endmodule // pesw_mgmt_model
`default_nettype wire

// ### verification/tb_top.sv
// Purpose: self-checking bench of the event status window
// Assumes: window reads checked through a queue of expected data
// Notes: status inputs driven 2 ns after the rising edge
`include "pesw_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pesw_pkg::*;
    localparam int CW = 8;
    logic sys_clk, resetn, mgmt_wr, mgmt_rd, mgmt_rvalid, firmware_in_rom, firmware_reset_seen;
    logic [4:0] mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, basic_status, support_status, gigabit_status;
    logic [CW-1:0] negotiation_counter, negotiation_count_limit;
    logic [CW-1:0] link_count_10, link_count_100, link_count_1000;
    logic [CW+1:0] link_count_limit;
    logic [7:0] idle_error_limit, event_status_low, event_status_high, exp_lo, exp_hi;
    logic [15:0] expq[$];
    logic [31:0] rnd;
    integer seed = 32'h825f;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int ord[13] = '{5, 0, 1, 2, 3, 4, 6, 7, 8, 9, 10, 11, 12};
    int bitn[13] = '{7, 6, 5, 4, 3, 2, 1, 0, 7, 6, 5, 4, 3};

    pesw_event_window #(.CW(CW)) u_pesw_event_window (.sys_clk(sys_clk), .resetn(resetn),
        .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .basic_status(basic_status),
        .support_status(support_status), .gigabit_status(gigabit_status),
        .negotiation_counter(negotiation_counter),
        .negotiation_count_limit(negotiation_count_limit), .link_count_10(link_count_10),
        .link_count_100(link_count_100), .link_count_1000(link_count_1000),
        .link_count_limit(link_count_limit), .idle_error_limit(idle_error_limit),
        .firmware_in_rom(firmware_in_rom), .firmware_reset_seen(firmware_reset_seen),
        .event_status_low(event_status_low), .event_status_high(event_status_high));
    pesw_mgmt_model u_pesw_mgmt_model (.sys_clk(sys_clk), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    task automatic rd_exp(input logic [4:0] a, input logic [15:0] e);
        expq.push_back(e);
        u_pesw_mgmt_model.rd(a);
    endtask
    // one event source per index
    task automatic kick(input int k, input logic on);
        case (k)
            0: negotiation_counter = on ? negotiation_count_limit + 8'h01 : 8'h00;
            1: basic_status[`PESW_BS_NEG_DONE] ^= 1'b1;
            2: basic_status[`PESW_BS_REM_FAULT] ^= 1'b1;
            3: support_status[`PESW_SS_SPEED_HI] ^= 1'b1;
            4: link_count_1000 = on ? 8'hFF : 8'h00;
            5: support_status[`PESW_SS_LINK] ^= 1'b1;
            6: support_status[`PESW_SS_DUPLEX] ^= 1'b1;
            7: basic_status[`PESW_BS_JABBER] ^= 1'b1;
            8: gigabit_status[`PESW_GS_CFG_FAULT] ^= 1'b1;
            9: gigabit_status[`PESW_GS_MASTER] ^= 1'b1;
            10: gigabit_status[`PESW_GS_LOC_RCVR] ^= 1'b1;
            11: gigabit_status[`PESW_GS_REM_RCVR] ^= 1'b1;
            default: gigabit_status[7:0] = on ? idle_error_limit + 8'h01 : 8'h00;
        endcase
    endtask

    // read checker pops the oldest note
    initial begin
        forever begin
            @(posedge sys_clk);
            #1;
            if (mgmt_rvalid === 1'b1) begin
                if (expq.size() == 0) check("spare rvalid", 16'h0001, 16'h0000);
                else check("rdata", mgmt_rdata, expq.pop_front());
            end
        end
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        basic_status = 16'h0000;
        support_status = 16'h0000;
        gigabit_status = 16'h0000;
        rnd = $random(seed);
        negotiation_counter = 8'h00;
        negotiation_count_limit = 8'h10 | rnd[6:0];
        idle_error_limit = 8'h10 | rnd[14:8];
        link_count_10 = 8'hFF;
        link_count_100 = 8'hFF;
        link_count_1000 = 8'h00;
        link_count_limit = 10'h200;
        firmware_in_rom = 1'b0;
        firmware_reset_seen = 1'b0;
        exp_lo = 8'h00;
        exp_hi = 8'h03;
        wait_n(12);
        resetn = 1'b1;
        check("reset low", {8'h00, event_status_low}, {8'h00, exp_lo});
        check("reset high", {8'h00, event_status_high}, {8'h00, exp_hi});
        rd_exp(`PESW_ADDR_DATA, `PESW_DATA_RST);
        rd_exp(`PESW_ADDR_PTR, `PESW_PTR_RST);
        rd_exp(`PESW_ADDR_MODE, {12'h000, `PESW_MODE_RST});
        u_pesw_mgmt_model.wr(`PESW_ADDR_DATA, 16'hA5C3);
        rd_exp(`PESW_ADDR_DATA, 16'hA5C3);
        rnd = $random(seed);
        u_pesw_mgmt_model.wr(`PESW_ADDR_PTR, rnd[15:0]);
        rd_exp(`PESW_ADDR_PTR, rnd[15:0]);
        rd_exp(5'h03, 16'h0000);
        u_pesw_mgmt_model.open_win(PESW_W_8);
        rd_exp(`PESW_ADDR_MODE, 16'h0005);
        u_pesw_mgmt_model.wr(`PESW_ADDR_PTR, `PESW_EXP_STAT_HI);
        rd_exp(`PESW_ADDR_DATA, {8'h00, exp_hi});
        u_pesw_mgmt_model.ack(`PESW_EXP_CLR_HI, 16'h0001);
        wait_n(1);
        exp_hi = 8'h02;
        check("ack reset bit", {8'h00, event_status_high}, {8'h00, exp_hi});
        for (int i = 0; i < 13; i++) begin
            kick(ord[i], 1'b1);
            wait_n(3);
            if (ord[i] >= 8) exp_hi[bitn[ord[i]]] = 1'b1;
            else exp_lo[bitn[ord[i]]] = 1'b1;
            check("event low", {8'h00, event_status_low}, {8'h00, exp_lo});
            check("event high", {8'h00, event_status_high}, {8'h00, exp_hi});
            if (ord[i] == 0 || ord[i] == 4 || ord[i] == 12) kick(ord[i], 1'b0);
            wait_n(2);
            u_pesw_mgmt_model.ack(ord[i] >= 8 ? `PESW_EXP_CLR_HI : `PESW_EXP_CLR_LO,
                16'h0001 << bitn[ord[i]]);
            wait_n(1);
            exp_lo = 8'h00;
            exp_hi = 8'h02;
            check("cleared low", {8'h00, event_status_low}, {8'h00, exp_lo});
            check("cleared high", {8'h00, event_status_high}, {8'h00, exp_hi});
        end
        kick(5, 1'b1);
        wait_n(2);
        kick(3, 1'b1);
        kick(6, 1'b1);
        kick(9, 1'b1);
        wait_n(3);
        exp_lo = 8'h04;
        check("gated low", {8'h00, event_status_low}, {8'h00, exp_lo});
        check("gated high", {8'h00, event_status_high}, {8'h00, exp_hi});
        u_pesw_mgmt_model.ack(`PESW_EXP_CLR_LO, 16'h0010);
        wait_n(1);
        check("unacked", {8'h00, event_status_low}, {8'h00, exp_lo});
        u_pesw_mgmt_model.open_win(PESW_W_16);
        u_pesw_mgmt_model.wr(`PESW_ADDR_PTR, `PESW_EXP_STAT_LO);
        rd_exp(`PESW_ADDR_DATA, {exp_hi, exp_lo});
        u_pesw_mgmt_model.ack(`PESW_EXP_CLR_LO, 16'h0004);
        wait_n(1);
        exp_lo = 8'h00;
        check("wide ack", {8'h00, event_status_low}, {8'h00, exp_lo});
        firmware_in_rom = 1'b1;
        firmware_reset_seen = 1'b1;
        wait_n(1);
        firmware_reset_seen = 1'b0;
        wait_n(2);
        exp_hi = 8'h05;
        check("firmware", {8'h00, event_status_high}, {8'h00, exp_hi});
        u_pesw_mgmt_model.wr(`PESW_ADDR_PTR, `PESW_EXP_STAT_HI);
        rd_exp(`PESW_ADDR_DATA, {8'h00, exp_hi});
        u_pesw_mgmt_model.open_win(2'b11);
        rd_exp(`PESW_ADDR_MODE, 16'h0007);
        rd_exp(`PESW_ADDR_DATA, 16'h0004);
        wait_n(2);
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
